// file: rtl/tweep_pkg.sv
// Shared constants for the two-wire memory slave and its bus master
package tweep_pkg;
  localparam logic [3:0] ID_ARRAY      = 4'hA;
  localparam logic [3:0] ID_REGS       = 4'hB;
  localparam logic [8:0] ADDR_FAULT    = 9'h0FF;
  localparam logic [8:0] ADDR_CONFIG   = 9'h1FF;
  localparam int         MEM_BYTES     = 512;
  localparam int         PAGE_BITS     = 4;
  localparam logic [7:0] CFG_SET_WL    = 8'h02;
  localparam logic [7:0] CFG_SET_RWL   = 8'h06;
  localparam int         CFG_WL_BIT    = 1;
  localparam int         CFG_RWL_BIT   = 2;
  localparam int         CFG_BP_BIT    = 4;
  localparam logic [8:0] PROT_BASE     = 9'h100;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] FAULT_RESET   = 8'h00;
  localparam int         CLK_HZ        = 40000000;
  localparam int         WRITE_CYC_US  = 5000;
  localparam int         WRITE_CYCLES  = CLK_HZ / 1000000 * WRITE_CYC_US;
  localparam int         SCL_HALF      = 100;
  // Master register offsets
  localparam logic [3:0] REG_CMD       = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_RDATA     = 4'h8;
  // Master command op codes
  localparam logic [2:0] OP_START      = 3'h1;
  localparam logic [2:0] OP_STOP       = 3'h2;
  localparam logic [2:0] OP_WRITE      = 3'h3;
  localparam logic [2:0] OP_READ       = 3'h4;
endpackage

// file: rtl/tweep_if.sv
// Two-wire bus carrier joining master and memory slave
`default_nettype none
interface tweep_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // Open-drain resolution with pull-ups
  assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
  assign sda = ((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o)) ? 1'b0 : 1'b1;
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
  modport device (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface
`default_nettype wire

// file: rtl/tweep_sync.sv
// Two-flop synchroniser for the bus lines
`default_nettype none
module tweep_sync (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Data
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  // Idle bus level is high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: rtl/tweep_slave.sv
// Two-wire memory slave: addressing, page writes, reads, write gating
// Functional notes
// - Byte write acked; commit only on stop
// - Busy during write cycle: ignore bus
// - No ack on protected-region write
// - Page write wraps low four bits
// - Extra page bytes overwrite buffered ones
// - Early stop: no write; mid-byte stop writes acked bytes
// - Polling: nack busy, ack when done
// - Slave byte: id, 00, addr8, direction
// - Direction one reads, zero writes
// - Config at 1FF, faults at 0FF
// - Counter serves current-address reads
// - Counter meaningless until first load
// - Master ends read with nack, stop
// - Random read via dummy write, restart
// - Stop after address loads counter
// - Sequential read wraps whole memory
// - Master stops after device gives up
// - Reset: standby, latch clear, SDA input
// - Array writes need write latch set
// - Protect pin blocks all writes
// - 02h, 06h, then settings byte
// - Nack mismatched slave byte and blocked writes
`default_nettype none
module tweep_slave #(
  parameter int WRITE_CYCLES = tweep_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Protect pin, asynchronous
  input  wire logic wp,
  // Status
  output logic      busy,
  output logic      write_latch_bit,
  // Bus
  tweep_if.device   bus
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_RX = 5'b00010, S_ACK = 5'b00100, S_TX = 5'b01000, S_MACK = 5'b10000
  } tweep_state_type;
  typedef enum logic [2:0] {P_DEV = 3'b001, P_ADR = 3'b010, P_DAT = 3'b100} tweep_phase_type;

  tweep_state_type st_q;
  tweep_phase_type ph_q;
  logic [7:0]  mem [tweep_pkg::MEM_BYTES];
  logic [7:0]  page_q [16];
  logic [15:0] pvalid_q;
  logic [7:0]  sh_q;
  logic [3:0]  bit_q;
  logic [8:0]  ctr_q;
  logic        regs_q;
  logic        wr_ok_q;
  logic        nack_q;
  logic        armed_q;
  logic [31:0] busy_q;
  logic [7:0]  config_control;
  logic [7:0]  fault_cause_flags;
  logic        register_write_latch_bit;
  logic        cfg_pend_q;
  logic [7:0]  cfg_new_q;
  logic        scl_s, sda_s, wp_s, scl_p, sda_p;
  logic        start_ev, stop_ev, scl_rise, scl_fall, protected_w;

  tweep_sync u_scl (.aclk(aclk), .aresetn(aresetn), .d(bus.scl), .q(scl_s));
  tweep_sync u_sda (.aclk(aclk), .aresetn(aresetn), .d(bus.sda), .q(sda_s));
  tweep_sync u_wp  (.aclk(aclk), .aresetn(aresetn), .d(wp), .q(wp_s));

  // Edge history of synchronised lines
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end
  // Inputs are disabled during the write cycle
  assign start_ev = scl_s && scl_p && sda_p && !sda_s && busy_q == 0;
  assign stop_ev  = scl_s && scl_p && !sda_p && sda_s && busy_q == 0;
  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;
  // Write lock from pin or missing latch; block-protect bit locks upper half
  assign protected_w = wp_s || !write_latch_bit
                       || (config_control[tweep_pkg::CFG_BP_BIT] && ctr_q >= tweep_pkg::PROT_BASE);
  assign busy = busy_q != 0;

  // Protocol engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE;
      ph_q <= P_DEV;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ctr_q <= 9'h000; // value carries no meaning until loaded
      regs_q <= 1'b0;
      wr_ok_q <= 1'b1;
      nack_q <= 1'b0;
      armed_q <= 1'b0;
      pvalid_q <= 16'h0000;
      bus.sda_s_o <= 1'b1;
      bus.sda_s_oe <= 1'b0;
    end else if (start_ev) begin
      st_q <= S_RX; // repeated start restarts addressing
      ph_q <= P_DEV;
      bit_q <= 4'h0;
      armed_q <= 1'b0;
      pvalid_q <= 16'h0000;
      bus.sda_s_oe <= 1'b0;
    end else if (stop_ev) begin
      st_q <= S_IDLE; // counter already loaded, standby
      bus.sda_s_oe <= 1'b0;
      pvalid_q <= 16'h0000;
      armed_q <= 1'b0;
    end else begin
      unique case (st_q)
        S_IDLE: bus.sda_s_oe <= 1'b0;
        S_RX: if (scl_rise) begin
          sh_q <= {sh_q[6:0], sda_s};
          bit_q <= bit_q + 4'h1;
        end else if (scl_fall && bit_q == 4'h8) begin
          bit_q <= 4'h0;
          st_q <= S_ACK;
          bus.sda_s_o <= 1'b0;
          bus.sda_s_oe <= 1'b1;
          armed_q <= 1'b0; // a new byte voids the earlier ack until acked
          unique case (ph_q)
            P_DEV: begin
              // identifier and zero select bits must match
              if ((sh_q[7:4] == tweep_pkg::ID_ARRAY || sh_q[7:4] == tweep_pkg::ID_REGS) && sh_q[3:2] == 2'b00) begin
                regs_q <= sh_q[7:4] == tweep_pkg::ID_REGS;
                ctr_q[8] <= sh_q[7:4] == tweep_pkg::ID_REGS ? sh_q[1] : ctr_q[8];
                if (sh_q[7:4] == tweep_pkg::ID_ARRAY && !sh_q[0]) ctr_q[8] <= sh_q[1];
                ph_q <= sh_q[0] ? P_DAT : P_ADR;
                nack_q <= sh_q[0];
              end else begin
                st_q <= S_IDLE;
                bus.sda_s_oe <= 1'b0;
              end
            end
            P_ADR: begin
              ctr_q[7:0] <= sh_q;
              ph_q <= P_DAT;
              nack_q <= 1'b0;
              wr_ok_q <= 1'b1;
            end
            default: begin
              if (regs_q) begin
                // Fault register needs no latch; config needs pin low and single byte
                wr_ok_q <= !wp_s && (ctr_q == tweep_pkg::ADDR_FAULT || pvalid_q == 16'h0000);
                if (wp_s || (ctr_q != tweep_pkg::ADDR_FAULT && pvalid_q != 16'h0000)) bus.sda_s_oe <= 1'b0;
                else begin
                  armed_q <= 1'b1;
                  pvalid_q[0] <= 1'b1;
                  page_q[0] <= sh_q;
                end
              end else if (protected_w) begin
                bus.sda_s_oe <= 1'b0;
                wr_ok_q <= 1'b0;
              end else begin
                page_q[ctr_q[3:0]] <= sh_q;
                pvalid_q[ctr_q[3:0]] <= 1'b1;
                ctr_q[3:0] <= ctr_q[3:0] + 4'h1;
              end
            end
          endcase
        end
        S_ACK: if (scl_fall) begin
          bus.sda_s_oe <= 1'b0;
          armed_q <= ph_q == P_DAT && !nack_q && pvalid_q != 16'h0000 && wr_ok_q;
          if (nack_q) begin
            st_q <= S_TX; // current address read
            sh_q <= regs_q ? (ctr_q == tweep_pkg::ADDR_CONFIG ? config_control : fault_cause_flags) : mem[ctr_q];
            if (!regs_q) ctr_q <= ctr_q + 9'h001;
            // Open drain: a one is sent by letting go of the line
            bus.sda_s_o <= 1'b0;
            bus.sda_s_oe <= !(regs_q ? (ctr_q == tweep_pkg::ADDR_CONFIG ? config_control[7] : fault_cause_flags[7])
                                     : mem[ctr_q][7]);
            bit_q <= 4'h1;
          end else st_q <= S_RX;
        end
        S_TX: if (scl_fall) begin
          if (bit_q == 4'h8) begin
            bus.sda_s_oe <= 1'b0;
            st_q <= S_MACK;
          end else begin
            bus.sda_s_o <= 1'b0;
            bus.sda_s_oe <= !sh_q[3'h7 - bit_q[2:0]];
            bit_q <= bit_q + 4'h1;
          end
        end
        S_MACK: if (scl_rise) begin
          // master nack ends output until next start
          st_q <= sda_s ? S_IDLE : S_ACK;
          nack_q <= !sda_s;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Self-timed nonvolatile write after a qualifying stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 32'd0;
    end else if (stop_ev && armed_q && !regs_q) begin
      busy_q <= 32'(WRITE_CYCLES);
    end else if (busy_q != 0) begin
      busy_q <= busy_q - 32'd1;
    end
  end

  // Page commit at the start of the write cycle
  always_ff @(posedge aclk) begin
    if (stop_ev && armed_q && !regs_q) begin
      for (int i = 0; i < 16; i++) begin
        if (pvalid_q[i]) mem[{ctr_q[8:4], 4'(i)}] <= page_q[i];
      end
    end
  end

  // Register writes and latches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_control <= tweep_pkg::CFG_RESET;
      fault_cause_flags <= tweep_pkg::FAULT_RESET;
      write_latch_bit <= 1'b0;
      register_write_latch_bit <= 1'b0;
    end else if (stop_ev && armed_q && regs_q) begin
      if (ctr_q == tweep_pkg::ADDR_FAULT) fault_cause_flags <= page_q[0];
      else if (ctr_q == tweep_pkg::ADDR_CONFIG) begin
        if (page_q[0] == tweep_pkg::CFG_SET_WL && !register_write_latch_bit) write_latch_bit <= 1'b1;
        else if (page_q[0][tweep_pkg::CFG_RWL_BIT] && write_latch_bit) register_write_latch_bit <= 1'b1;
        else if (register_write_latch_bit) begin
          config_control <= {page_q[0][7:3], 1'b0, page_q[0][1:0]};
          register_write_latch_bit <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/tweep_master.sv
// Two-wire bus master driven by AXI4-Lite command registers
`default_nettype none
module tweep_master (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Bus
  tweep_if.master          bus
);
  logic [2:0]  op_q;
  logic [7:0]  tx_q, rx_q;
  logic        ack_q, run_q, got_aw, got_w;
  logic [3:0]  aw_q;
  logic [11:0] wd_q;
  logic [7:0]  div_q;
  logic [5:0]  ph_q;
  logic        sda_s;

  tweep_sync u_sda (.aclk(aclk), .aresetn(aresetn), .d(bus.sda), .q(sda_s));

  // Write channel: address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1; wready <= 1'b1; bvalid <= 1'b0; bresp <= 2'b00;
      got_aw <= 1'b0; got_w <= 1'b0; aw_q <= 4'h0; wd_q <= 12'h000;
    end else begin
      if (awvalid && awready) begin got_aw <= 1'b1; aw_q <= awaddr; awready <= 1'b0; end
      // Data is kept here: the source may drop it once taken
      if (wvalid && wready) begin got_w <= 1'b1; wready <= 1'b0; wd_q <= wdata[11:0]; end
      if (got_aw && got_w && !bvalid) begin
        bvalid <= 1'b1;
        bresp <= (aw_q == tweep_pkg::REG_CMD) ? 2'b00 : 2'b10;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0; got_aw <= 1'b0; got_w <= 1'b0; awready <= 1'b1; wready <= 1'b1;
      end
    end
  end
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1; rvalid <= 1'b0; rdata <= 32'h0; rresp <= 2'b00;
    end else if (arvalid && arready) begin
      arready <= 1'b0; rvalid <= 1'b1;
      rresp <= (araddr == tweep_pkg::REG_STATUS || araddr == tweep_pkg::REG_RDATA) ? 2'b00 : 2'b10;
      rdata <= araddr == tweep_pkg::REG_STATUS ? {30'h0, ack_q, run_q} : {24'h0, rx_q};
    end else if (rvalid && rready) begin
      rvalid <= 1'b0; arready <= 1'b1;
    end
  end
  // Bit engine: quarter phases of SCL from divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0; op_q <= 3'h0; tx_q <= 8'h00; rx_q <= 8'h00; ack_q <= 1'b0;
      div_q <= 8'h00; ph_q <= 6'h00;
      bus.scl_o <= 1'b1; bus.scl_oe <= 1'b0; bus.sda_m_o <= 1'b1; bus.sda_m_oe <= 1'b0;
    end else if (!run_q) begin
      if (got_aw && got_w && !bvalid && aw_q == tweep_pkg::REG_CMD) begin
        run_q <= 1'b1; op_q <= wd_q[10:8]; tx_q <= wd_q[7:0]; ph_q <= 6'h00; div_q <= 8'h00;
        if (wd_q[10:8] == tweep_pkg::OP_READ) ack_q <= wd_q[11];
      end
    end else if (div_q != 8'(tweep_pkg::SCL_HALF / 2 - 1)) begin
      div_q <= div_q + 8'h01;
    end else begin
      div_q <= 8'h00;
      ph_q <= ph_q + 6'h01;
      // Each bit is four quarters: data set, rise, sample, fall
      unique case (op_q)
        tweep_pkg::OP_START: begin
          unique case (ph_q[1:0])
            2'd0: begin bus.sda_m_o <= 1'b1; bus.sda_m_oe <= 1'b0; end
            2'd1: begin bus.scl_o <= 1'b1; bus.scl_oe <= 1'b0; end
            2'd2: begin bus.sda_m_o <= 1'b0; bus.sda_m_oe <= 1'b1; end
            default: begin bus.scl_o <= 1'b0; bus.scl_oe <= 1'b1; run_q <= 1'b0; end
          endcase
        end
        tweep_pkg::OP_STOP: begin
          unique case (ph_q[1:0])
            2'd0: begin bus.sda_m_o <= 1'b0; bus.sda_m_oe <= 1'b1; end
            2'd1: begin bus.scl_o <= 1'b1; bus.scl_oe <= 1'b0; end
            2'd2: begin bus.sda_m_o <= 1'b1; bus.sda_m_oe <= 1'b0; end
            default: run_q <= 1'b0;
          endcase
        end
        default: begin
          // Write sends tx then samples ack; read samples then sends ack bit
          unique case (ph_q[1:0])
            2'd0: begin
              if (op_q == tweep_pkg::OP_WRITE && ph_q[5:2] < 4'd8) begin
                bus.sda_m_o <= tx_q[3'd7 - ph_q[4:2]]; bus.sda_m_oe <= !tx_q[3'd7 - ph_q[4:2]];
              end else if (op_q == tweep_pkg::OP_READ && ph_q[5:2] == 4'd8) begin
                bus.sda_m_o <= ack_q; bus.sda_m_oe <= !ack_q;
              end else begin
                bus.sda_m_o <= 1'b1; bus.sda_m_oe <= 1'b0;
              end
            end
            2'd1: begin bus.scl_o <= 1'b1; bus.scl_oe <= 1'b0; end
            2'd2: begin
              if (ph_q[5:2] < 4'd8) rx_q <= {rx_q[6:0], sda_s};
              else if (op_q == tweep_pkg::OP_WRITE) ack_q <= !sda_s;
            end
            default: begin
              bus.scl_o <= 1'b0; bus.scl_oe <= 1'b1;
              if (ph_q[5:2] == 4'd8) begin run_q <= 1'b0; bus.sda_m_oe <= 1'b0; bus.sda_m_o <= 1'b1; end
            end
          endcase
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: dv/tweep_monitor.sv
// Checker watching the two-wire link and the memory slave status pins
`default_nettype none
module tweep_monitor #(
  parameter int WRITE_CYCLES = 200
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Slave status and protect pin
  input wire logic wp,
  input wire logic busy,
  input wire logic write_latch_bit,
  // Link drivers and resolved lines
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] busy_cnt_q;
  // Length of the running write cycle, counted rather than unrolled
  always_ff @(posedge aclk) begin
    if (!aresetn || !busy) busy_cnt_q <= 32'h0;
    else busy_cnt_q <= busy_cnt_q + 32'h1;
  end
  property p_rst_idle;
    $rose(aresetn) |-> !sda_s_oe && !write_latch_bit && !busy;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("slave not idle after reset");
  property p_busy_quiet;
    busy |-> !sda_s_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("slave drives data while busy");
  property p_od;
    sda_s_oe |-> !sda_s_o;
  endproperty
  a_od: assert property (p_od) else $error("slave data pin not open drain");
  // Slave may only move its data line while the clock is low
  property p_sda_hold;
    $changed(sda_s_oe) |-> !scl;
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("slave data changed with clock high");
  property p_busy_stop;
    $rose(busy) |-> scl && sda;
  endproperty
  a_busy_stop: assert property (p_busy_stop) else $error("write cycle began outside a stop");
  property p_busy_len;
    $fell(busy) |-> busy_cnt_q >= WRITE_CYCLES - 2 && busy_cnt_q <= WRITE_CYCLES + 2;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_wp_block;
    $rose(busy) |-> !wp && !$past(wp, 3);
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("write cycle while protect pin high");
  property p_start_master;
    $fell(sda) && scl && $past(scl) |-> sda_m_oe;
  endproperty
  a_start_master: assert property (p_start_master) else $error("start not made by master");
  property p_latch_stop;
    $rose(write_latch_bit) |-> scl && sda;
  endproperty
  a_latch_stop: assert property (p_latch_stop) else $error("latch set outside a stop");
  c_write_done: cover property ($fell(busy));
  c_latch_set: cover property ($rose(write_latch_bit));
  c_slave_ack: cover property ($rose(sda_s_oe));
endmodule
`default_nettype wire

// file: dv/test_tweep.sv
// Bench: AXI4-Lite driven master against the memory slave
`default_nettype none
module test_tweep;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WCYC = 5000;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        wp = 1'b0;
  logic        busy, write_latch_bit, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, dout;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        ak;
  logic [7:0]  rd;
  logic [7:0]  mem [16];
  int          error_cnt = 0, tests_run = 0;
  tweep_if link ();
  tweep_slave #(.WRITE_CYCLES(WCYC)) tweep_slave_i (.bus(link.device), .*);
  tweep_master tweep_master_i (.bus(link.master), .*);
  tweep_monitor #(.WRITE_CYCLES(WCYC)) tweep_monitor_i (.scl_o(link.scl_o), .scl_oe(link.scl_oe),
    .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe),
    .scl(link.scl), .sda(link.sda), .*);
  // 40 MHz clock
  always #12.5 aclk = ~aclk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chkb(input logic b, input logic e);
    chk({7'h00, b}, {7'h00, e});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No assumed latency: only the watchdog ends a wait
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    dout = rdata;
    rready <= 1'b0;
  endtask
  // One link command, then status polled until the master is idle again
  task automatic op(input logic [2:0] o, input logic [7:0] b, input logic nk);
    axi_wr(tweep_pkg::REG_CMD, {20'h0, nk, o, b});
    dout = 32'h1;
    for (int n = 0; n < 2000 && dout[0]; n++) axi_rd(tweep_pkg::REG_STATUS);
    ak = dout[1];
  endtask
  task automatic wb(input logic [7:0] b);
    op(tweep_pkg::OP_WRITE, b, 1'b0);
  endtask
  task automatic rb(input logic nk);
    op(tweep_pkg::OP_READ, 8'h00, nk);
    axi_rd(tweep_pkg::REG_RDATA);
    rd = dout[7:0];
  endtask
  task automatic stop();
    op(tweep_pkg::OP_STOP, 8'h00, 1'b0);
  endtask
  task automatic sel(input logic [3:0] id, input logic [8:0] a, input logic rw);
    op(tweep_pkg::OP_START, 8'h00, 1'b0);
    wb({id, 2'b00, a[8], rw});
  endtask
  task automatic setadr(input logic [3:0] id, input logic [8:0] a);
    sel(id, a, 1'b0);
    chkb(ak, 1'b1);
    wb(a[7:0]);
    chkb(ak, 1'b1);
  endtask
  task automatic wr1(input logic [3:0] id, input logic [8:0] a, input logic [7:0] d, input logic ex);
    setadr(id, a);
    wb(d);
    chkb(ak, ex);
    stop();
  endtask
  // Hang guard: the sequence needs roughly 120k cycles
  initial begin
    repeat (300000) @(posedge aclk);
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chkb(write_latch_bit, 1'b0);
    wr1(tweep_pkg::ID_ARRAY, 9'h020, 8'h11, 1'b0);
    chkb(busy, 1'b0);
    wr1(tweep_pkg::ID_REGS, tweep_pkg::ADDR_FAULT, 8'hD8, 1'b1);
    setadr(tweep_pkg::ID_REGS, tweep_pkg::ADDR_FAULT);
    sel(tweep_pkg::ID_REGS, tweep_pkg::ADDR_FAULT, 1'b1);
    rb(1'b1);
    chk(rd, 8'hD8);
    stop();
    wr1(tweep_pkg::ID_REGS, tweep_pkg::ADDR_CONFIG, tweep_pkg::CFG_SET_WL, 1'b1);
    chkb(write_latch_bit, 1'b1);
    $display("test latch_and_registers done");
    // Page write from location 10, one byte past a full page
    setadr(tweep_pkg::ID_ARRAY, 9'h00A);
    for (int i = 0; i < 17; i++) begin
      wb(8'h40 + i[7:0]);
      chkb(ak, 1'b1);
      mem[(10 + i) % 16] = 8'h40 + i[7:0];
    end
    stop();
    chkb(busy, 1'b1);
    sel(tweep_pkg::ID_ARRAY, 9'h000, 1'b0);
    chkb(ak, 1'b0);
    stop();
    for (int n = 0; n < 4 * WCYC && busy !== 1'b0; n++) @(posedge aclk);
    sel(tweep_pkg::ID_ARRAY, 9'h000, 1'b0);
    chkb(ak, 1'b1);
    stop();
    $display("test page_write_and_polling done");
    // Random read of three bytes, then the counter continues
    setadr(tweep_pkg::ID_ARRAY, 9'h00A);
    sel(tweep_pkg::ID_ARRAY, 9'h00A, 1'b1);
    chkb(ak, 1'b1);
    for (int i = 0; i < 3; i++) begin
      rb(i == 2);
      chk(rd, mem[10 + i]);
    end
    stop();
    sel(tweep_pkg::ID_ARRAY, 9'h000, 1'b1);
    rb(1'b1);
    chk(rd, mem[13]);
    stop();
    // Address load without data must not start a write
    setadr(tweep_pkg::ID_ARRAY, 9'h1FF);
    stop();
    chkb(busy, 1'b0);
    sel(tweep_pkg::ID_ARRAY, 9'h1FF, 1'b1);
    rb(1'b0);
    rb(1'b1);
    chk(rd, mem[0]);
    stop();
    sel(4'h5, 9'h000, 1'b0);
    chkb(ak, 1'b0);
    stop();
    $display("test reads_and_addressing done");
    wp <= 1'b1;
    setadr(tweep_pkg::ID_ARRAY, 9'h030);
    wb(8'h77);
    stop();
    chkb(busy, 1'b0);
    wp <= 1'b0;
    wr1(tweep_pkg::ID_REGS, tweep_pkg::ADDR_CONFIG, tweep_pkg::CFG_SET_RWL, 1'b1);
    wr1(tweep_pkg::ID_REGS, tweep_pkg::ADDR_CONFIG, 8'h12, 1'b1);
    wr1(tweep_pkg::ID_ARRAY, 9'h140, 8'h55, 1'b0);
    chkb(busy, 1'b0);
    $display("test protection done");
    close_out();
  end
endmodule
`default_nettype wire
